// >>> verilog/ssd_top.sv
`timescale 1ns/10ps
// ==========================================================
// Stall detector step decode and modulus down-counter
module ssd_top
#(
  parameter int ADDR_W = 5
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_overflow_pulse,
  output logic [1:0] cos_current,
  output logic [1:0] sin_current,
  output logic [3:0] integrator_route,
  output logic [3:0] reference_route,
  output logic converter_reset,
  output logic accumulator_clear,
  output logic irq
);
  // ==========================================================
  // Complete block state
  typedef struct packed
  {
    logic wait_req;
    logic [31:0] rdata;
    logic [1:0] step;
    logic integrate;
    logic drive;
    logic polarity;
    logic uf_ie;
    logic reload;
    logic rd_load;
    logic pre_sel;
    logic cnt_en;
    logic ov_ie;
    logic pre_active;
    logic [15:0] count;
    logic [15:0] load;
    logic uf_flag;
    logic ov_flag;
    logic [1:0] mask;
    logic irq;
    logic [1:0] cos_cur;
    logic [1:0] sin_cur;
    logic [3:0] int_sel;
    logic [3:0] ref_sel;
    logic conv_rst;
    logic acc_clr;
  } ssd_top_state_s;

  ssd_top_state_s st_reg; // Registered state
  ssd_top_state_s st_next; // Next state

  // ==========================================================
  // Helper signals
  logic tick; // Prescaled tick
  logic restart; // Restart the prescaler period
  logic [2:0] idx; // Register index
  logic aligned; // Low address bits are zero
  logic done; // Bus access completes at this edge
  logic wr_acc; // Write completes now
  logic rd_acc; // Read completes now
  logic lane0; // Low byte lane enabled
  logic lane1; // Second byte lane enabled
  logic force_wr; // Force-load written as one
  logic cnt_wr; // Count register written
  logic [15:0] new_load; // Load value after this write
  logic transfer; // Load moved into count
  logic uf_event; // Counter stepped down from one on a tick
  logic [7:0] step_rd; // Step control read view
  logic [7:0] ctl_rd; // Control read view
  logic [7:0] flag_rd; // Flag read view
  logic [1:0] cos_n; // Decoded cosine current
  logic [1:0] sin_n; // Decoded sine current
  logic [3:0] int_n; // Decoded integrator route
  logic [3:0] ref_n; // Decoded reference route

  // ==========================================================
  // Prescaler
  // Rate follows the select latched at the last load transfer
  ssd_prescaler u_pre
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(restart),
    .div_slow(st_reg.pre_active),
    .tick(tick)
  );

  // ==========================================================
  // Step decode
  ssd_step_router u_route
  (
    .step(st_reg.step),
    .drive(st_reg.drive),
    .integrate(st_reg.integrate),
    .polarity(st_reg.polarity),
    .cos_cur(cos_n),
    .sin_cur(sin_n),
    .int_sel(int_n),
    .ref_sel(ref_n)
  );

  // ==========================================================
  // Bus decode
  assign idx = avs_address[ADDR_W-1:2];
  // Misaligned accesses complete but touch no register
  assign aligned = (avs_address[1:0] == 2'h0);
  assign done = !st_reg.wait_req;
  assign wr_acc = avs_write && done && aligned;
  assign rd_acc = avs_read && done && aligned;
  assign lane0 = avs_byteenable[0];
  assign lane1 = avs_byteenable[1];
  assign force_wr = wr_acc && lane0 && (idx == ssd_pkg::IDX_DC_CTL)
    && avs_writedata[ssd_pkg::B_FORCE];
  assign cnt_wr = wr_acc && (idx == ssd_pkg::IDX_COUNT)
    && (lane0 || lane1);

  // Load value as updated by a count write, byte lanes honoured
  always_comb
  begin
    new_load = st_reg.load;
    if (cnt_wr && lane0)
      new_load[7:0] = avs_writedata[7:0];
    if (cnt_wr && lane1)
      new_load[15:8] = avs_writedata[15:8];
  end

  // ==========================================================
  // Read views of the byte registers
  always_comb
  begin
    step_rd = 8'h00;
    step_rd[ssd_pkg::B_INTEGRATE] = st_reg.integrate;
    step_rd[ssd_pkg::B_DRIVE] = st_reg.drive;
    step_rd[ssd_pkg::B_POLARITY] = st_reg.polarity;
    step_rd[1:0] = st_reg.step;
    ctl_rd = 8'h00;
    ctl_rd[ssd_pkg::B_UF_IE] = st_reg.uf_ie;
    ctl_rd[ssd_pkg::B_RELOAD] = st_reg.reload;
    ctl_rd[ssd_pkg::B_RD_LOAD] = st_reg.rd_load;
    ctl_rd[ssd_pkg::B_PRESCALE] = st_reg.pre_sel;
    ctl_rd[ssd_pkg::B_FORCE] = 1'b0;
    ctl_rd[ssd_pkg::B_CNT_EN] = st_reg.cnt_en;
    ctl_rd[ssd_pkg::B_OV_IE] = st_reg.ov_ie;
    flag_rd = 8'h00;
    flag_rd[ssd_pkg::B_UF_FLAG] = st_reg.uf_flag;
    flag_rd[ssd_pkg::B_OV_FLAG] = st_reg.ov_flag;
  end

  // ==========================================================
  // Next state of the whole block
  always_comb
  begin
    st_next = st_reg;
    transfer = 1'b0;
    uf_event = 1'b0;
    restart = 1'b0;

    // Bus handshake: one wait cycle, then one completing cycle
    st_next.wait_req = !((avs_read || avs_write) && st_reg.wait_req);
    if (avs_read && st_reg.wait_req)
    begin
      // Read data prepared for the completing edge
      // Unused bits read as zero
      st_next.rdata = 32'h0000_0000;
      if (aligned)
      begin
        case (idx)
          ssd_pkg::IDX_STEP_CTL: st_next.rdata[7:0] = step_rd;
          ssd_pkg::IDX_DC_CTL: st_next.rdata[7:0] = ctl_rd;
          ssd_pkg::IDX_FLAG: st_next.rdata[7:0] = flag_rd;
          ssd_pkg::IDX_COUNT:
            st_next.rdata[15:0] = st_reg.rd_load ? st_reg.load
              : st_reg.count;
          ssd_pkg::IDX_IRQ_MASK:
          begin
            // Mask bits sit at the flag positions
            st_next.rdata[ssd_pkg::B_UF_FLAG] = st_reg.mask[1];
            st_next.rdata[ssd_pkg::B_OV_FLAG] = st_reg.mask[0];
          end
          default: st_next.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes at the completing edge
    if (wr_acc && lane0)
    begin
      case (idx)
        ssd_pkg::IDX_STEP_CTL:
        begin
          // Step state, coil drive and routing
          st_next.integrate = avs_writedata[ssd_pkg::B_INTEGRATE];
          st_next.drive = avs_writedata[ssd_pkg::B_DRIVE];
          st_next.polarity = avs_writedata[ssd_pkg::B_POLARITY];
          st_next.step = avs_writedata[1:0];
        end
        ssd_pkg::IDX_DC_CTL:
        begin
          // Control is writable in every state
          st_next.uf_ie = avs_writedata[ssd_pkg::B_UF_IE];
          st_next.reload = avs_writedata[ssd_pkg::B_RELOAD];
          st_next.rd_load = avs_writedata[ssd_pkg::B_RD_LOAD];
          st_next.pre_sel = avs_writedata[ssd_pkg::B_PRESCALE];
          st_next.cnt_en = avs_writedata[ssd_pkg::B_CNT_EN];
          st_next.ov_ie = avs_writedata[ssd_pkg::B_OV_IE];
        end
        ssd_pkg::IDX_IRQ_MASK:
        begin
          // Mask of the interrupt output
          st_next.mask[1] = avs_writedata[ssd_pkg::B_UF_FLAG];
          st_next.mask[0] = avs_writedata[ssd_pkg::B_OV_FLAG];
        end
        default: st_next.mask = st_reg.mask;
      endcase
    end
    // Load register takes count writes even while disabled
    st_next.load = new_load;

    // Down-counter
    if (!st_reg.cnt_en)
    begin
      // Preset while disabled avoids an early underflow
      st_next.count = ssd_pkg::COUNT_PRESET;
      restart = 1'b1;
    end
    else if (force_wr || cnt_wr)
    begin
      // Immediate copy of the load value
      st_next.count = new_load;
      transfer = 1'b1;
    end
    else if (tick && (st_reg.count != 16'h0000))
    begin
      // Count on a tick; a zero count stays parked
      if (st_reg.count == 16'h0001)
      begin
        // Last step, taken from a count of one, raises the flag
        uf_event = 1'b1;
        if (st_reg.reload)
        begin
          // Reload mode starts again from the load value
          st_next.count = st_reg.load;
          transfer = 1'b1;
        end
        else
        begin
          // One-shot mode parks at zero
          st_next.count = 16'h0000;
        end
      end
      else
      begin
        // Ordinary decrement
        st_next.count = st_reg.count - 16'h0001;
      end
    end
    if (transfer)
    begin
      // Prescale choice follows the transfer
      st_next.pre_active = st_reg.pre_sel;
      restart = 1'b1;
    end

    // Flags: read or write-one clears, a new event wins
    // A read clears only what it reported, so an event landing
    // between the sampling and the completing edge is kept
    if (rd_acc && (idx == ssd_pkg::IDX_FLAG))
    begin
      if (st_reg.rdata[ssd_pkg::B_UF_FLAG])
        st_next.uf_flag = 1'b0;
      if (st_reg.rdata[ssd_pkg::B_OV_FLAG])
        st_next.ov_flag = 1'b0;
    end
    if (wr_acc && lane0 && (idx == ssd_pkg::IDX_FLAG))
    begin
      if (avs_writedata[ssd_pkg::B_UF_FLAG])
        st_next.uf_flag = 1'b0;
      if (avs_writedata[ssd_pkg::B_OV_FLAG])
        st_next.ov_flag = 1'b0;
    end
    // Hardware events come last so that a set beats a clear
    if (uf_event)
      st_next.uf_flag = 1'b1;
    if (acc_overflow_pulse)
      st_next.ov_flag = 1'b1;

    // Interrupt from enabled, unmasked flags
    st_next.irq = (st_next.uf_flag && st_next.uf_ie && st_next.mask[1])
      || (st_next.ov_flag && st_next.ov_ie && st_next.mask[0]);

    // Coil and switch outputs
    st_next.cos_cur = cos_n;
    st_next.sin_cur = sin_n;
    st_next.int_sel = int_n;
    st_next.ref_sel = ref_n;
    // Blanking lags the select by a cycle, in step with the routes
    st_next.conv_rst = !st_reg.integrate;
    st_next.acc_clr = !st_reg.integrate;
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      // Idle bus holds waitrequest high
      st_reg.wait_req <= 1'b1;
      st_reg.count <= ssd_pkg::COUNT_PRESET;
      st_reg.load <= ssd_pkg::LOAD_RESET;
      st_reg.mask <= ssd_pkg::MASK_RESET;
      // Blanking while the integrate select is clear
      st_reg.conv_rst <= 1'b1;
      st_reg.acc_clr <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs straight from the state registers
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.wait_req;
  assign cos_current = st_reg.cos_cur;
  assign sin_current = st_reg.sin_cur;
  assign integrator_route = st_reg.int_sel;
  assign reference_route = st_reg.ref_sel;
  assign converter_reset = st_reg.conv_rst;
  assign accumulator_clear = st_reg.acc_clr;
  assign irq = st_reg.irq;
endmodule

// >>> verilog/ssd_pkg.sv
package ssd_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [2:0] IDX_STEP_CTL = 3'h0; // Step and coil control
  localparam logic [2:0] IDX_DC_CTL = 3'h1; // Down-counter control
  localparam logic [2:0] IDX_FLAG = 3'h3; // Event flags
  localparam logic [2:0] IDX_COUNT = 3'h4; // Count and load value
  localparam logic [2:0] IDX_IRQ_MASK = 3'h5; // Interrupt mask
  // ==========================================================
  // Step control field positions
  localparam int B_INTEGRATE = 7; // Integrate select
  localparam int B_DRIVE = 6; // Drive coil select
  localparam int B_POLARITY = 4; // Node polarity
  // Down-counter control field positions
  localparam int B_UF_IE = 7; // Underflow interrupt enable
  localparam int B_RELOAD = 6; // Reload mode
  localparam int B_RD_LOAD = 5; // Read-load select
  localparam int B_PRESCALE = 4; // Prescale select
  localparam int B_FORCE = 3; // Force load
  localparam int B_CNT_EN = 2; // Counter enable
  localparam int B_OV_IE = 0; // Overflow interrupt enable
  // Flag and mask field positions
  localparam int B_UF_FLAG = 7; // Underflow flag
  localparam int B_OV_FLAG = 0; // Accumulator overflow flag
  // ==========================================================
  // Reset and preset values
  localparam logic [15:0] COUNT_PRESET = 16'hFFFF; // Disabled count
  localparam logic [15:0] LOAD_RESET = 16'h0000; // Load after reset
  localparam logic [1:0] MASK_RESET = 2'h3; // Mask after reset
  // ==========================================================
  // Prescaler division counts
  localparam logic [8:0] DIV_SLOW_LAST = 9'h1FF; // Divide by 512
  localparam logic [8:0] DIV_FAST_LAST = 9'h03F; // Divide by 64
  // ==========================================================
  // Coil current codes
  localparam logic [1:0] CUR_ZERO = 2'h0; // No current
  localparam logic [1:0] CUR_PLUS = 2'h1; // Plus maximum
  localparam logic [1:0] CUR_MINUS = 2'h2; // Minus maximum
  // Coil node one-hot positions
  localparam int N_SIN_P = 0; // Sine plus node
  localparam int N_SIN_M = 1; // Sine minus node
  localparam int N_COS_P = 2; // Cosine plus node
  localparam int N_COS_M = 3; // Cosine minus node
endpackage

// >>> verilog/ssd_prescaler.sv
`timescale 1ns/10ps
// ==========================================================
// Tick generator for the down-counter
module ssd_prescaler
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic div_slow,
  output logic tick
);
  // Divider state
  typedef struct packed
  {
    logic [8:0] cnt;
    logic tick;
  } ssd_pre_state_s;

  ssd_pre_state_s st_reg;
  ssd_pre_state_s st_next;
  logic [8:0] last;

  // Next divider state
  always_comb
  begin
    st_next = st_reg;
    last = div_slow ? ssd_pkg::DIV_SLOW_LAST : ssd_pkg::DIV_FAST_LAST;
    st_next.tick = 1'b0;
    if (restart)
    begin
      // Begin a fresh period
      st_next.cnt = 9'h000;
    end
    else if (st_reg.cnt >= last)
    begin
      // End of period gives one tick
      st_next.cnt = 9'h000;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 9'h001;
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;
endmodule

// >>> verilog/ssd_step_router.sv
`timescale 1ns/10ps
// ==========================================================
// Full-step decode of coil currents and node routing
module ssd_step_router
(
  input wire logic [1:0] step,
  input wire logic drive,
  input wire logic integrate,
  input wire logic polarity,
  output logic [1:0] cos_cur,
  output logic [1:0] sin_cur,
  output logic [3:0] int_sel,
  output logic [3:0] ref_sel
);
  logic swap;

  // Currents and switch selection
  always_comb
  begin
    cos_cur = ssd_pkg::CUR_ZERO;
    sin_cur = ssd_pkg::CUR_ZERO;
    int_sel = 4'h0;
    ref_sel = 4'h0;
    swap = polarity ^ step[1];
    if (drive)
    begin
      case (step)
        2'h0: cos_cur = ssd_pkg::CUR_PLUS;
        2'h1: sin_cur = ssd_pkg::CUR_PLUS;
        2'h2: cos_cur = ssd_pkg::CUR_MINUS;
        2'h3: sin_cur = ssd_pkg::CUR_MINUS;
        default: cos_cur = ssd_pkg::CUR_ZERO;
      endcase
    end
    if (integrate)
    begin
      if (!step[0])
      begin
        // Sine coil is the idle one
        int_sel[swap ? ssd_pkg::N_SIN_P : ssd_pkg::N_SIN_M] = 1'b1;
        ref_sel[swap ? ssd_pkg::N_SIN_M : ssd_pkg::N_SIN_P] = 1'b1;
      end
      else
      begin
        // Cosine coil is the idle one
        int_sel[swap ? ssd_pkg::N_COS_M : ssd_pkg::N_COS_P] = 1'b1;
        ref_sel[swap ? ssd_pkg::N_COS_P : ssd_pkg::N_COS_M] = 1'b1;
      end
    end
  end
endmodule

// >>> test/ssd_top_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for step decode, routing and register bus
module ssd_checker
#(
  parameter int ADDR_W = 5
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic acc_overflow_pulse,
  input wire logic [1:0] cos_current,
  input wire logic [1:0] sin_current,
  input wire logic [3:0] integrator_route,
  input wire logic [3:0] reference_route,
  input wire logic converter_reset,
  input wire logic accumulator_clear,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Bus answers after one wait cycle, for one cycle only
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  answer_single_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Force-load bit reads back as zero
  force_reads_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h04
    |-> avs_readdata[3] == 1'b0)
    else $error("force-load bit read as one");
  // Only one coil carries current at a time
  coil_exclusive_a: assert property (
    cos_current == ssd_pkg::CUR_ZERO || sin_current == ssd_pkg::CUR_ZERO)
    else $error("both coils carry current");
  // Blanking opens every switch and clears the accumulator
  blank_open_a: assert property (
    converter_reset |-> integrator_route == 4'h0
    && reference_route == 4'h0 && accumulator_clear)
    else $error("switch closed during blanking");
  // Integration closes one node to each input, same coil
  route_pair_a: assert property (
    !converter_reset |-> $onehot(integrator_route)
    && (integrator_route | reference_route) inside {4'h3, 4'hC})
    else $error("routing not one node each of one coil");
  // Driven cosine means the sine coil is sensed
  sine_sensed_a: assert property (
    !converter_reset && cos_current != ssd_pkg::CUR_ZERO
    |-> integrator_route[1:0] != 2'h0)
    else $error("sine coil not routed while cosine driven");
  cos_sensed_a: assert property (
    !converter_reset && sin_current != ssd_pkg::CUR_ZERO
    |-> integrator_route[3:2] != 2'h0)
    else $error("cosine coil not routed while sine driven");
  // Interrupt only drops after a completed bus access
  irq_drop_a: assert property (
    $fell(irq) |-> $past(avs_waitrequest) == 1'b0)
    else $error("interrupt dropped without bus access");
endmodule
bind ssd_top ssd_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

// >>> test/ssd_coil_model.sv
`timescale 1ns/10ps
// ==========================================================
// Stepper coil pair: rotor pole pulled by coil currents
module ssd_coil_model
(
  input wire logic [1:0] cos_current,
  input wire logic [1:0] sin_current,
  output logic [2:0] pole
);
  // Pole: pulled flag and angle step, zero when undriven
  always_comb
  begin
    pole = 3'h0;
    if (cos_current == ssd_pkg::CUR_PLUS) pole = 3'h4;
    if (sin_current == ssd_pkg::CUR_PLUS) pole = 3'h5;
    if (cos_current == ssd_pkg::CUR_MINUS) pole = 3'h6;
    if (sin_current == ssd_pkg::CUR_MINUS) pole = 3'h7;
  end
endmodule

// >>> test/ssd_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED %s expected %h seen %h", \
  nm, e, g); end end
// ==========================================================
// Bench for step decode and modulus down-counter
module ssd_top_tb;
  localparam logic [4:0] A_STEP = 5'h00; // Step control
  localparam logic [4:0] A_CTL = 5'h04; // Counter control
  localparam logic [4:0] A_FLAG = 5'h0C; // Flags
  localparam logic [4:0] A_CNT = 5'h10; // Count and load
  localparam logic [4:0] A_MASK = 5'h14; // Interrupt mask
  logic clk_sys, sys_rst, avs_read, avs_write, acc_overflow_pulse;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, integrator_route, reference_route;
  logic avs_waitrequest, converter_reset, accumulator_clear, irq;
  logic [1:0] cos_current, sin_current;
  logic [2:0] pole;
  int err_total, compares;
  ssd_top #(.ADDR_W(5)) dut_u (.*);
  ssd_coil_model coil_u (.cos_current, .sin_current, .pole);
  // Clock at 100 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Reset values and an unmapped address
  task t_reset;
    `CHK("cvt_rst", 1'b1, converter_reset)
    bus(1'b0, A_CTL, 32'h0);
    `CHK("ctl", 32'h0, rd)
    bus(1'b0, A_MASK, 32'h0);
    `CHK("mask", 32'h81, rd)
    bus(1'b0, A_CNT, 32'h0);
    `CHK("preset", 32'hFFFF, rd)
    bus(1'b0, 5'h08, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  // Every step, polarity, drive and integrate combination
  task automatic t_steps;
    logic [1:0] st, ec, es;
    logic pl, dr, it, sw;
    logic [3:0] ei, er;
    for (int i = 0; i < 32; i++)
    begin
      {it, dr, pl, st} = 5'(i);
      bus(1'b1, A_STEP, {24'h0, it, dr, 1'b0, pl, 2'h0, st});
      clks(2);
      ec = (dr && !st[0]) ? (st[1] ? 2'h2 : 2'h1) : 2'h0;
      es = (dr && st[0]) ? (st[1] ? 2'h2 : 2'h1) : 2'h0;
      sw = pl ^ st[1];
      ei = st[0] ? (sw ? 4'h8 : 4'h4) : (sw ? 4'h1 : 4'h2);
      er = st[0] ? (sw ? 4'h4 : 4'h8) : (sw ? 4'h2 : 4'h1);
      if (!it)
      begin
        ei = 4'h0;
        er = 4'h0;
      end
      `CHK("cos", ec, cos_current)
      `CHK("sin", es, sin_current)
      `CHK("int", ei, integrator_route)
      `CHK("ref", er, reference_route)
      `CHK("cvt_rst", !it, converter_reset)
      `CHK("acc_clr", !it, accumulator_clear)
      `CHK("pole", {dr, dr ? st : 2'h0}, pole)
    end
  endtask
  // Tick rate, delayed rate change, read-back and force load
  task t_counter;
    bus(1'b1, A_CTL, 32'h04);
    bus(1'b1, A_CNT, 32'h0100);
    clks(200);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("div64", 32'h00FD, rd)
    bus(1'b1, A_CTL, 32'h34);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("load_rd", 32'h0100, rd)
    bus(1'b1, A_CTL, 32'h14);
    clks(120);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("old_rate", 32'h00FB, rd)
    bus(1'b1, A_CTL, 32'h1C);
    bus(1'b0, A_CTL, 32'h0);
    `CHK("force_rd", 32'h14, rd)
    bus(1'b0, A_CNT, 32'h0);
    `CHK("forced", 32'h0100, rd)
    clks(600);
    bus(1'b1, A_CTL, 32'h14);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("div512", 32'h00FF, rd)
  endtask
  // One-shot underflow, flag and interrupt enable
  task t_oneshot;
    bus(1'b1, A_CTL, 32'h0);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("preset", 32'hFFFF, rd)
    bus(1'b1, A_CTL, 32'h84);
    bus(1'b1, A_CNT, 32'h2);
    clks(170);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("zero", 32'h0, rd)
    `CHK("uf_irq", 1'b1, irq)
    clks(200);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("halted", 32'h0, rd)
    bus(1'b1, A_FLAG, 32'h0);
    `CHK("w0_keep", 1'b1, irq)
    bus(1'b1, A_CTL, 32'h04);
    `CHK("ie_off", 1'b0, irq)
    bus(1'b1, A_CTL, 32'h84);
    `CHK("ie_on", 1'b1, irq)
    bus(1'b1, A_FLAG, 32'h80);
    `CHK("w1_clr", 1'b0, irq)
  endtask
  // Reload mode, changed while disabled
  task t_reload;
    bus(1'b1, A_CTL, 32'h0);
    bus(1'b1, A_CTL, 32'h40);
    bus(1'b1, A_CTL, 32'h44);
    bus(1'b1, A_CNT, 32'h3);
    clks(215);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("reloaded", 32'h3, rd)
    bus(1'b0, A_FLAG, 32'h0);
    `CHK("uf_flag", 32'h80, rd)
    bus(1'b1, A_CNT, 32'h0);
    clks(150);
    bus(1'b0, A_CNT, 32'h0);
    `CHK("zero_stay", 32'h0, rd)
    bus(1'b0, A_FLAG, 32'h0);
    `CHK("zero_noflag", 32'h0, rd)
    avs_byteenable <= 4'h2;
    bus(1'b1, A_CNT, 32'h0500);
    avs_byteenable <= 4'hF;
    bus(1'b0, A_CNT, 32'h0);
    `CHK("hi_lane", 32'h0500, rd)
  endtask
  // Accumulator overflow interrupt, masked and read
  task t_overflow;
    bus(1'b1, A_CTL, 32'h01);
    acc_overflow_pulse <= 1'b1;
    @(posedge clk_sys);
    acc_overflow_pulse <= 1'b0;
    clks(2);
    `CHK("ov_irq", 1'b1, irq)
    bus(1'b1, A_MASK, 32'h80);
    `CHK("masked", 1'b0, irq)
    bus(1'b0, A_FLAG, 32'h0);
    `CHK("ov_flag", 32'h01, rd)
    bus(1'b0, A_FLAG, 32'h0);
    `CHK("rd_clear", 32'h0, rd)
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    {sys_rst, avs_read, avs_write, acc_overflow_pulse} = 4'h8;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    err_total = 0;
    compares = 0;
    clks(6);
    sys_rst <= 1'b0;
    t_reset();
    t_steps();
    t_counter();
    t_oneshot();
    t_reload();
    t_overflow();
    tally_and_finish();
  end
endmodule
